// File: core/eprom_prog_pkg.sv
// Package of constants for the EPROM programming controller.
// Behaviour
// (R1) Erased bits read one; programming only turns selected bits to zero.
// (R2) No electrical operation returns a zero bit to one.
// (R3) Program mode when program supply is at program level and select low.
// (R4) Programmer presents the whole byte on all eight data pins at once.
// (R5) Each program pulse holds select low between 95 and 105 us.
// (R6) Address stable at least 2 us before select falls.
// (R7) Write data stable at least 2 us before select falls.
// (R8) Write data kept driven at least 2 us after select rises.
// (R9) Data pins released at least 2 us before output enable falls.
// (R10) Address held until output enable returns high after verify.
// (R11) Repeat 100 us pulses, each followed by verify, until byte matches; the code gives up after MAX_PULSES (25) pulses.
// (R12) No extra overprogram pulse once a byte verifies.
// (R13) Device enables margin checking itself during program and verify.
// (R14) A device with select high is not programmed under program supply.
// (R15) Parallel devices share all lines but each has its own select.
// (R16) Verify with output enable low, select high, supplies at program level.
// (R17) Read back each programmed location to confirm its bits.
// (R18) Identification mode by high voltage on line nine, normal supplies.
// (R19) Line zero low gives maker code, high gives part code.
// (R20) In identification mode all other address lines are held low.
// (R21) Device leaves data pins undriven while select low and enable high.
package eprom_prog_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int DEV_N  = 4;
  localparam int ID_LINE_BIT  = 9;
  localparam int SIG_SEL_BIT  = 0;

  // ----------------------------------------------------------------------
  // Timing in nanoseconds and derived cycle counts at 20 MHz
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int T_SETUP_NS      = 2000;   // Address, data and supply setup.
  localparam int T_PULSE_NS      = 100000; // Nominal program pulse.
  localparam int T_PULSE_MIN_NS  = 95000;
  localparam int T_PULSE_MAX_NS  = 105000;
  localparam int T_HOLD_NS       = 2000;   // Data hold after select rises.
  localparam int T_RELEASE_NS    = 2000;   // Data release before verify.
  localparam int T_OE_VALID_NS   = 100;    // Output enable to valid data.
  localparam int T_SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int T_PULSE_CYC   = T_PULSE_NS / CLK_PERIOD_NS;
  localparam int T_HOLD_CYC    = (T_HOLD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int T_RELEASE_CYC = (T_RELEASE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // Two extra cycles cover the two-stage input synchroniser.
  localparam int T_OE_CYC      = (T_OE_VALID_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS + 2;
  localparam int CNT_W         = 13;

  // ----------------------------------------------------------------------
  // Retry limit and results
  // ----------------------------------------------------------------------
  localparam logic [7:0] MAX_PULSES = 8'h19;
  localparam logic [1:0] RES_OK     = 2'h0;
  localparam logic [1:0] RES_FAIL   = 2'h1;
  localparam logic [1:0] RES_ONEBIT = 2'h2;
  localparam logic [1:0] RES_READ   = 2'h3;

  // Commands from the user side.
  localparam logic [1:0] CMD_PROGRAM = 2'h0;
  localparam logic [1:0] CMD_READ    = 2'h1;
  localparam logic [1:0] CMD_IDENT   = 2'h2;

  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_SETUP   = 9'h002,
    ST_PULSE   = 9'h004,
    ST_HOLD    = 9'h008,
    ST_RELEASE = 9'h010,
    ST_VERIFY  = 9'h020,
    ST_CHECK   = 9'h040,
    ST_DONE    = 9'h080,
    ST_READ    = 9'h100
  } prog_state_t;

endpackage

// File: core/pin_sync.sv
// Two-stage synchroniser for the data pins read back from the devices.
`timescale 1ns/1ns
module pin_sync
  import eprom_prog_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // Pins in, synchronised out
  input  wire logic [DATA_W-1:0] pin_in,
  output logic      [DATA_W-1:0] sync_out
);

  logic [DATA_W-1:0] meta_r;
  logic [DATA_W-1:0] sync_r;

  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// File: core/cycle_timer.sv
// Down-counter that times each phase of the programming sequence.
`timescale 1ns/1ns
module cycle_timer
  import eprom_prog_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  // Load and status
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  done_out
);

  logic [CNT_W-1:0] cnt_r;

  // Loading count N makes done rise N cycles after the load edge.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (load_in) begin
      cnt_r <= count_in;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Done depends on the count only: the sequencer loads on done, so
  // masking done with load would close a combinational loop.
  assign done_out = (cnt_r == '0);

endmodule

// File: core/eprom_programmer.sv
// Programmer that writes, verifies and identifies parallel EPROMs.
`timescale 1ns/1ns
module eprom_programmer
  import eprom_prog_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // User command port
  input  wire logic              cmd_valid_in,
  input  wire logic [1:0]        cmd_op_in,
  input  wire logic [DEV_N-1:0]  cmd_dev_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [DATA_W-1:0] cmd_data_in,
  output logic                   cmd_ready_out,
  output logic                   rsp_valid_out,
  output logic [1:0]             rsp_code_out,
  output logic [DATA_W-1:0]      rsp_data_out,
  output logic [7:0]             rsp_pulses_out,
  // Device pins
  output logic [ADDR_W-1:0]      addr_out,
  input  wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic                   data_pins_oe_out,
  output logic [DEV_N-1:0]       chip_sel_n_out,
  output logic                   out_en_n_out,
  output logic                   vpp_prog_out,
  output logic                   vcc_prog_out,
  output logic                   id_mode_address_line_out
);

  // ----------------------------------------------------------------------
  // State and working registers
  // ----------------------------------------------------------------------
  prog_state_t       state_r;
  logic [DEV_N-1:0]  dev_r;
  logic [DEV_N-1:0]  pend_r;
  logic [DATA_W-1:0] want_r;
  logic [7:0]        pulses_r;
  logic              first_r;
  logic [1:0]        op_r;
  logic [DATA_W-1:0] rdata;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_count;
  logic              tmr_done;
  logic [DEV_N-1:0]  cur_dev;
  logic [DEV_N-1:0]  pend_nxt;

  pin_sync u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .pin_in      (data_pins_in),
    .sync_out    (rdata)
  );

  cycle_timer u_timer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .load_in     (tmr_load),
    .count_in    (tmr_count),
    .done_out    (tmr_done)
  );

  // Lowest pending device is the one being worked on.
  assign cur_dev = pend_r & (~pend_r + 1'b1); // R15

  // ----------------------------------------------------------------------
  // Timer loads on each phase entry
  // ----------------------------------------------------------------------
  // One load per phase keeps every interval measured from the same edge.
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    unique case (state_r)
      ST_IDLE: begin
        tmr_load  = cmd_valid_in;
        tmr_count = CNT_W'(T_SETUP_CYC); // R6 R7
      end
      ST_SETUP: begin
        tmr_load  = tmr_done;
        tmr_count = CNT_W'(T_PULSE_CYC); // R5 R11
      end
      ST_PULSE: begin
        tmr_load  = tmr_done;
        tmr_count = CNT_W'(T_HOLD_CYC); // R8
      end
      ST_HOLD: begin
        tmr_load  = tmr_done;
        tmr_count = CNT_W'(T_RELEASE_CYC); // R9
      end
      ST_RELEASE: begin
        tmr_load  = tmr_done;
        tmr_count = CNT_W'(T_OE_CYC);
      end
      ST_CHECK: begin
        tmr_load  = 1'b1;
        tmr_count = CNT_W'(T_SETUP_CYC);
      end
      ST_VERIFY, ST_DONE, ST_READ: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Verify decision
  // ----------------------------------------------------------------------
  // A device that verifies drops out; others keep pulsing.
  always_comb begin
    pend_nxt = pend_r;
    if (rdata == want_r) begin
      pend_nxt = pend_r & ~cur_dev; // R11 R12
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r  <= ST_IDLE;
      dev_r    <= '0;
      pend_r   <= '0;
      want_r   <= '1;
      pulses_r <= '0;
      first_r  <= 1'b0;
      op_r     <= CMD_READ;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_valid_in) begin
            op_r     <= cmd_op_in;
            dev_r    <= cmd_dev_in;
            pend_r   <= cmd_dev_in;
            want_r   <= cmd_data_in;
            pulses_r <= '0;
            // Blank devices are read first so no pulse lands on a
            // byte that already matches.
            first_r  <= 1'b1;
            state_r  <= (cmd_op_in == CMD_PROGRAM) ? ST_RELEASE : ST_READ;
          end
        end
        ST_READ: begin
          if (tmr_done) begin
            state_r <= ST_VERIFY;
          end
        end
        ST_SETUP: begin
          if (tmr_done) begin
            state_r  <= ST_PULSE;
            pulses_r <= pulses_r + 8'h01;
          end
        end
        ST_PULSE: begin
          if (tmr_done) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (tmr_done) begin
            state_r <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (tmr_done) begin
            state_r <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          if (tmr_done) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          first_r <= 1'b0;
          if (op_r != CMD_PROGRAM) begin
            state_r <= ST_DONE;
          end else begin
            pend_r <= pend_nxt; // R17
            if (pend_nxt == '0) begin
              state_r <= ST_DONE; // R12
            end else if ((want_r & ~rdata) != '0
                         || pulses_r == MAX_PULSES) begin
              // A zero cannot be raised to one, so stop at once.
              state_r <= ST_DONE; // R2
            end else if (pend_nxt != pend_r) begin
              state_r <= ST_RELEASE;
            end else begin
              state_r <= ST_SETUP; // R11
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rsp_valid_out  <= 1'b0;
      rsp_code_out   <= RES_OK;
      rsp_data_out   <= '0;
      rsp_pulses_out <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (state_r == ST_CHECK) begin
        rsp_data_out   <= rdata;
        rsp_pulses_out <= pulses_r;
        if (op_r != CMD_PROGRAM) begin
          rsp_code_out <= RES_READ;
        end else if (pend_nxt == '0) begin
          rsp_code_out <= RES_OK;
        end else if ((want_r & ~rdata) != '0) begin
          rsp_code_out <= RES_ONEBIT; // R1
        end else begin
          rsp_code_out <= RES_FAIL;
        end
      end
      if (state_r == ST_DONE) begin
        rsp_valid_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // Address is captured at the command and held through the whole verify.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      addr_out                 <= '0;
      id_mode_address_line_out <= 1'b0;
    end else if (state_r == ST_IDLE && cmd_valid_in) begin
      if (cmd_op_in == CMD_IDENT) begin
        addr_out <= ADDR_W'({cmd_addr_in[SIG_SEL_BIT]}); // R20 R19
        id_mode_address_line_out <= 1'b1; // R18
      end else begin
        addr_out                 <= cmd_addr_in; // R6 R10
        id_mode_address_line_out <= 1'b0;
      end
    end
  end

  // Supplies sit at program level for program and verify of a byte only.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      vpp_prog_out <= 1'b0;
      vcc_prog_out <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      vpp_prog_out <= cmd_valid_in && cmd_op_in == CMD_PROGRAM; // R3 R16
      vcc_prog_out <= cmd_valid_in && cmd_op_in == CMD_PROGRAM; // R16
    end else if (state_r == ST_DONE) begin
      vpp_prog_out <= 1'b0;
      vcc_prog_out <= 1'b0;
    end
  end

  // Only the device being programmed sees select low; others are inhibited.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      chip_sel_n_out <= '1;
    end else if (state_r == ST_SETUP && tmr_done) begin
      chip_sel_n_out <= ~cur_dev; // R3 R14 R15
    end else if (state_r == ST_PULSE && tmr_done) begin
      chip_sel_n_out <= '1; // R5
    end else if (state_r == ST_IDLE && cmd_valid_in
                 && cmd_op_in != CMD_PROGRAM) begin
      chip_sel_n_out <= ~cmd_dev_in;
    end else if (state_r == ST_DONE) begin
      chip_sel_n_out <= '1;
    end
  end

  // Data drives from setup to end of hold, never during verify.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_pins_out    <= '1;
      data_pins_oe_out <= 1'b0;
    end else if (state_r == ST_CHECK && op_r == CMD_PROGRAM) begin
      data_pins_out    <= want_r; // R4 R7
      data_pins_oe_out <= pend_nxt != '0 && (want_r & ~rdata) == '0
                          && pend_nxt == pend_r && pulses_r != MAX_PULSES;
    end else if (state_r == ST_HOLD && tmr_done) begin
      data_pins_oe_out <= 1'b0; // R8 R9
    end
  end

  // Output enable falls for a read and rises before the address moves.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      out_en_n_out <= 1'b1;
    end else if (state_r == ST_RELEASE && tmr_done) begin
      out_en_n_out <= 1'b0; // R9 R16
    end else if (state_r == ST_IDLE && cmd_valid_in
                 && cmd_op_in != CMD_PROGRAM) begin
      out_en_n_out <= 1'b0;
    end else if (state_r == ST_VERIFY && tmr_done) begin
      out_en_n_out <= 1'b1; // R10
    end
  end

  // The idle code is one-hot bit 0, so ready is a flop output itself.
  assign cmd_ready_out = state_r[0];

endmodule

// File: bench/eprom_bank_model.sv
// Behavioural model of a bank of EPROM devices on shared pins.
`timescale 1ns/1ns
module eprom_bank_model
  import eprom_prog_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'hc3  // Arbitrary value.
)
(
  // Pins from the programmer
  input  wire logic              core_clk_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] host_data_in,
  input  wire logic              host_oe_in,
  input  wire logic [DEV_N-1:0]  chip_sel_n_in,
  input  wire logic              out_en_n_in,
  input  wire logic              vpp_prog_in,
  input  wire logic              vcc_prog_in,
  input  wire logic              id_line_in,
  // Pulses a byte needs, and the device seen in verify
  input  wire logic [5:0]        need_in,
  input  wire logic [1:0]        vdev_in,
  // Resolved data pins
  output logic      [DATA_W-1:0] bus_out
);
  logic [7:0]       mem [DEV_N][1 << ADDR_W];
  logic [5:0]       cnt [DEV_N];
  logic [DEV_N-1:0] prev_n;
  logic [7:0]       q;
  logic [7:0]       last;
  logic             drv;

  // Every cell starts erased.
  initial begin
    prev_n = '1;
    last = 8'h00;
    foreach (mem[i, j]) mem[i][j] = 8'hff;
    foreach (cnt[i]) cnt[i] = 6'h00;
  end

  // A pulse counts at its select rise; margin asks need_in of them.
  always @(chip_sel_n_in or vpp_prog_in) begin
    for (int i = 0; i < DEV_N; i++) begin
      if (!vpp_prog_in) begin
        cnt[i] = 6'h00;
      end else if (chip_sel_n_in[i] && !prev_n[i]) begin
        cnt[i] = cnt[i] + 6'h01;
        if (cnt[i] >= need_in) begin
          mem[i][addr_in] = mem[i][addr_in] & host_data_in;
          cnt[i] = 6'h00;
        end
      end
    end
    prev_n = chip_sel_n_in;
  end

  // Pins drive only with output enable low; select alone floats them.
  always_comb begin
    drv = 1'b0;
    q = 8'h00;
    if (!out_en_n_in && id_line_in && !vpp_prog_in) begin
      drv = 1'b1;
      q = addr_in[0] ? PART_CODE : MAKER_CODE;
    end else if (!out_en_n_in && vpp_prog_in && vcc_prog_in) begin
      drv = &chip_sel_n_in;
      q = mem[vdev_in][addr_in];
    end else if (!out_en_n_in) begin
      for (int i = DEV_N - 1; i >= 0; i--) begin
        if (!chip_sel_n_in[i]) begin
          drv = 1'b1;
          q = mem[i][addr_in];
        end
      end
    end
  end

  // A floating bus shows the inverse of its last value, never a hold.
  assign bus_out = drv ? q : (host_oe_in ? host_data_in : ~last);
  always @(posedge core_clk_in) begin
    if (drv || host_oe_in) begin
      last <= bus_out;
    end
  end
endmodule

// File: bench/eprom_programmer_monitor.sv
// Checker of the programmer's pin timing and mode combinations.
`timescale 1ns/1ns
module eprom_programmer_monitor
  import eprom_prog_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk_in,
  input wire logic              rst_in,
  // Device pins
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_pins_out,
  input wire logic              data_pins_oe_out,
  input wire logic [DEV_N-1:0]  chip_sel_n_out,
  input wire logic              out_en_n_out,
  input wire logic              vpp_prog_out,
  input wire logic              vcc_prog_out,
  input wire logic              id_mode_address_line_out
);
  // The setup counter lags its span by one edge after a data change, so 39 stands for 2 us; hold and release counters do not.
  localparam int SPAN = 39;
  logic [11:0] pw_cnt;
  logic [5:0]  s_cnt;
  logic [5:0]  h_cnt;
  logic [5:0]  r_cnt;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  function automatic logic [5:0] up(input logic [5:0] v);
    return (v == 6'h3f) ? v : v + 6'h01;
  endfunction

  // Span counters: pulse width, setup, hold after pulse, release.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pw_cnt <= 12'h000;
      s_cnt <= 6'h00;
      h_cnt <= 6'h00;
      r_cnt <= 6'h00;
    end else begin
      pw_cnt <= (&chip_sel_n_out) ? 12'h000 : pw_cnt + 12'h001;
      s_cnt <= ($changed(addr_out) || $changed(data_pins_out) ||
                !data_pins_oe_out) ? 6'h00 : up(s_cnt);
      h_cnt <= (&chip_sel_n_out) ? up(h_cnt) : 6'h00;
      r_cnt <= data_pins_oe_out ? 6'h00 : up(r_cnt);
    end
  end

  sequence s_pulse_start; $fell(&chip_sel_n_out) && vpp_prog_out; endsequence
  sequence s_pulse_end; $rose(&chip_sel_n_out) && vpp_prog_out; endsequence
  sequence s_verify; $fell(out_en_n_out) && vpp_prog_out; endsequence

  property p_pulse_width; s_pulse_end |-> pw_cnt inside {[1900:2100]};
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("Program pulse width outside limits.");
  property p_setup; s_pulse_start |-> data_pins_oe_out && s_cnt >= SPAN;
  endproperty
  a_setup: assert property (p_setup)
    else $error("Address or data not settled before pulse.");
  property p_hold; $fell(data_pins_oe_out) |-> h_cnt >= SPAN; endproperty
  a_hold: assert property (p_hold)
    else $error("Write data released too soon after pulse.");
  property p_release; s_verify |-> !data_pins_oe_out && r_cnt >= SPAN;
  endproperty
  a_release: assert property (p_release)
    else $error("Verify started too soon after data release.");
  property p_addr_hold;
    !out_en_n_out && !$past(out_en_n_out) |-> $stable(addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("Address moved during a read.");
  property p_prog_drive; !(&chip_sel_n_out) && vpp_prog_out |->
    data_pins_oe_out && out_en_n_out && vcc_prog_out; endproperty
  a_prog_drive: assert property (p_prog_drive)
    else $error("Program pulse without driven data.");
  property p_verify; !out_en_n_out && vpp_prog_out |->
    (&chip_sel_n_out) && vcc_prog_out && !data_pins_oe_out; endproperty
  a_verify: assert property (p_verify)
    else $error("Verify read with wrong pin levels.");
  property p_ident; id_mode_address_line_out |-> !vpp_prog_out &&
    !vcc_prog_out && (addr_out & 15'h7ffe) == 15'h0000; endproperty
  a_ident: assert property (p_ident)
    else $error("Identification mode with wrong supplies or address.");
endmodule

bind eprom_programmer eprom_programmer_monitor u_mon (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_out(addr_out),
  .data_pins_out(data_pins_out), .data_pins_oe_out(data_pins_oe_out),
  .chip_sel_n_out(chip_sel_n_out), .out_en_n_out(out_en_n_out),
  .vpp_prog_out(vpp_prog_out), .vcc_prog_out(vcc_prog_out),
  .id_mode_address_line_out(id_mode_address_line_out)
);

// File: bench/eprom_programmer_tb_top.sv
// Self-checking bench for the EPROM programming controller.
`timescale 1ns/1ns
module eprom_programmer_tb_top
  import eprom_prog_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
  localparam logic [7:0] PART  = 8'hc3; // Arbitrary value.
  logic core_clk_in, rst_in, cmd_valid_in, cmd_ready_out, rsp_valid_out;
  logic [1:0] cmd_op_in, rsp_code_out, vdev;
  logic [3:0] cmd_dev_in, chip_sel_n_out;
  logic [14:0] cmd_addr_in, addr_out;
  logic [7:0] cmd_data_in, rsp_data_out, rsp_pulses_out, data_pins_in;
  logic [7:0] data_pins_out, d;
  logic data_pins_oe_out, out_en_n_out, vpp_prog_out, vcc_prog_out, id_l;
  logic [5:0] need;
  logic [31:0] rng;
  int fails, check_count;

  eprom_programmer dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_dev_in(cmd_dev_in),
    .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_code_out(rsp_code_out), .rsp_data_out(rsp_data_out),
    .rsp_pulses_out(rsp_pulses_out), .addr_out(addr_out),
    .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
    .data_pins_oe_out(data_pins_oe_out), .chip_sel_n_out(chip_sel_n_out),
    .out_en_n_out(out_en_n_out), .vpp_prog_out(vpp_prog_out),
    .vcc_prog_out(vcc_prog_out), .id_mode_address_line_out(id_l));
  eprom_bank_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) model (
    .core_clk_in(core_clk_in), .addr_in(addr_out),
    .host_data_in(data_pins_out), .host_oe_in(data_pins_oe_out),
    .chip_sel_n_in(chip_sel_n_out), .out_en_n_in(out_en_n_out),
    .vpp_prog_in(vpp_prog_out), .vcc_prog_in(vcc_prog_out),
    .id_line_in(id_l), .need_in(need), .vdev_in(vdev),
    .bus_out(data_pins_in));

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected result code and pulse count of one program command.
  function automatic logic [9:0] exp_prog(input logic [7:0] old,
                                          input logic [7:0] want,
                                          input logic [5:0] nd);
    logic [1:0] code;
    logic [7:0] np;
    code = ((~old & want) != 8'h00) ? RES_ONEBIT : RES_OK;
    np = (code != RES_OK || old == want) ? 8'h00 : {2'b00, nd};
    if (nd > MAX_PULSES && code == RES_OK && old != want) begin
      code = RES_FAIL;
      np = MAX_PULSES;
    end
    return {code, np};
  endfunction

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One command: raise valid while ready, then wait for the response.
  task automatic run(input logic [1:0] op, input logic [3:0] dev,
                     input logic [14:0] a, input logic [7:0] dat);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (cmd_ready_out !== 1'b1 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    cmd_op_in = op;
    cmd_dev_in = dev;
    cmd_addr_in = a;
    cmd_data_in = dat;
    cmd_valid_in = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
    while (rsp_valid_out !== 1'b1 && n < 60000) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 60000) begin
      fails++;
    end
  endtask

  // Program a byte, then read it back and read the neighbour device.
  task automatic prog(input int k, input logic [14:0] a,
                      input logic [7:0] old, input logic [7:0] want);
    logic [1:0] code;
    logic [7:0] np;
    logic [9:0] e;
    e = exp_prog(old, want, need);
    code = e[9:8];
    np = e[7:0];
    vdev = 2'(k);
    run(CMD_PROGRAM, 4'h1 << k, a, want);
    check("program code", {6'h00, rsp_code_out}, {6'h00, code});
    check("pulse count", rsp_pulses_out, np);
    run(CMD_READ, 4'h1 << k, a, 8'h00);
    check("read code", {6'h00, rsp_code_out}, {6'h00, RES_READ});
    check("stored byte", rsp_data_out, code == RES_OK ? want : old);
    run(CMD_READ, 4'h1 << (k ^ 1), a, 8'h00);
    check("inhibited byte", rsp_data_out, 8'hff);
  endtask

  // Watchdog about half again beyond the expected run of about 63000
  // cycles, so a hang still ends well inside the run budget.
  initial begin
    #(95000 * 50);
    fails++;
    end_sim();
  end

  initial begin
    rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_op_in = 2'h0;
    cmd_dev_in = 4'h0;
    cmd_addr_in = 15'h0000;
    cmd_data_in = 8'h00;
    need = 6'h01;
    vdev = 2'h0;
    rng = 32'h0000_1f31;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    // Random bytes with bit 0 clear, one to three pulses each.
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      need = 6'h01 + 6'(rng[25:24] % 2'h3);
      prog(int'(rng[23:22]), {i[1:0], rng[20:8]}, 8'hff, rng[7:0] & 8'hfe);
    end
    // Same byte again needs no pulse; a wanted 1 over a 0 is refused.
    d = rng[7:0] & 8'hfe;
    prog(int'(rng[23:22]), {2'h2, rng[20:8]}, d, d);
    prog(int'(rng[23:22]), {2'h2, rng[20:8]}, d, d | 8'h01);
    // A byte that never reaches margin gives up at the pulse limit.
    need = 6'h1a;
    prog(0, 15'h7000, 8'hff, 8'h00);
    // Both identification bytes.
    run(CMD_IDENT, 4'h1, 15'h0000, 8'h00);
    check("maker code", rsp_data_out, MAKER);
    run(CMD_IDENT, 4'h1, 15'h0001, 8'h00);
    check("part code", rsp_data_out, PART);
    end_sim();
  end
endmodule
